// ==== ramp_seq_pkg.sv ====
`default_nettype none
package ramp_seq_pkg;
  // geometry
  localparam int NUM_SEG = 8;
  localparam int SEG_W   = 3;
  localparam int ACC_W   = 33;
  localparam int INC_W   = 30;
  localparam int LEN_W   = 16;
  localparam int CNT_W   = 17;
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int NUM_TRIG = 3;

  // register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS      = 8'h00;
  localparam logic [ADDR_W-1:0] LIMIT_LOW_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] LIMIT_HIGH_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] STATUS_OFS    = 8'h0c;
  localparam logic [ADDR_W-1:0] ACC_OFS       = 8'h10;
  // segment block: base + 8*index, word 0 increment, word 1 configuration
  localparam logic [1:0]        SEG_AREA      = 2'h1;

  // control fields
  localparam int CTRL_EN_BIT        = 0;
  localparam int CTRL_CLR_BIT       = 1;
  localparam int CTRL_LOW_MSB_BIT   = 2;
  localparam int CTRL_HIGH_MSB_BIT  = 3;

  // segment configuration fields
  localparam int CFG_LEN_LSB  = 0;
  localparam int CFG_HALF_BIT = 16;
  localparam int CFG_FL_BIT   = 17;
  localparam int CFG_FLAG_LSB = 18;
  localparam int CFG_ADV_LSB  = 20;
  localparam int CFG_NEXT_LSB = 22;
  localparam int CFG_W        = 25;

  // status fields
  localparam int STAT_SEG_LSB  = 0;
  localparam int STAT_RUN_BIT  = 3;
  localparam int STAT_MSB_BIT  = 4;
  localparam int STAT_FL_BIT   = 5;
  localparam int STAT_FLAG_LSB = 6;

  // reset values
  localparam logic [3:0]       CTRL_RST       = 4'h8;
  localparam logic [ACC_W-1:0] LIMIT_LOW_RST  = 33'h0_0000_0000;
  localparam logic [ACC_W-1:0] LIMIT_HIGH_RST = 33'h1_ffff_ffff;
  localparam logic [INC_W-1:0] INC_RST        = 30'h0000_0000;
  localparam logic [CFG_W-1:0] CFG_RST        = 25'h000_0000;

  // advance conditions
  localparam logic [1:0] ADV_LENGTH = 2'h0;

  // timing: phase-detector cycles per tick in half-rate mode
  localparam int          HALF_RATE_CYCLES = 2;
  localparam logic [CNT_W-1:0] LEN_FULL    = 17'h1_0000;

  typedef enum logic {SEQ_IDLE, SEQ_RUN} seq_state_e;
endpackage
`default_nettype wire

// ==== edge_sync.sv ====
`default_nettype none
module edge_sync (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // asynchronous level in, rising-edge pulse out
  input  wire logic async_in,
  output logic      rise_pulse
);
  logic s1_r, s2_r, s3_r, level_r, pulse_r;
  logic level_nxt, pulse_nxt;

  always_comb begin
    level_nxt = (s2_r == s3_r) ? s3_r : level_r;
    pulse_nxt = level_nxt & ~level_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_r <= 1'b0;
      pulse_r <= 1'b0;
    end else begin
      s1_r    <= async_in;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      level_r <= level_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  assign rise_pulse = pulse_r;
endmodule
`default_nettype wire

// ==== ramp_segment_sequencer.sv ====
// Design decisions made here: register access over APB and the placing of the registers.
`default_nettype none
// Overview of operation
// [R01] fastlock output follows running segment's bit
// [R02] half-rate segments tick every two cycles
// [R03] add signed increment per tick, length ticks
// [R04] flag outputs follow running segment's field
// [R05] clear bit forces accumulator to zero
// [R06] software clears accumulator at pattern start
// [R07] advance on length expiry or chosen trigger
// [R08] expiry jumps to segment's next index
// [R09] eight independent copies of segment fields
// [R10] accumulator held between signed limits
// [R11] fields reset zero, start at segment zero
module ramp_segment_sequencer
  import ramp_seq_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // trigger events, asynchronous
  input  wire logic              trigger_event_a,
  input  wire logic              trigger_event_b,
  input  wire logic              trigger_event_c,
  // ramp outputs
  output logic      [ACC_W-1:0]  ramp_accumulator,
  output logic                   flag_out_zero,
  output logic                   flag_out_one,
  output logic                   fastlock_active,
  output logic      [SEG_W-1:0]  active_segment,
  output logic                   ramp_running
);

  // trigger synchronisers
  // a trigger counts once, on its settled rising edge
  logic [NUM_TRIG-1:0] trig_in;
  logic [NUM_TRIG-1:0] trig_pulse;
  assign trig_in = {trigger_event_c, trigger_event_b, trigger_event_a};

  for (genvar g = 0; g < NUM_TRIG; g++) begin : g_trig
    edge_sync u_sync (
      .pclk      (pclk),
      .presetn   (presetn),
      .async_in  (trig_in[g]),
      .rise_pulse(trig_pulse[g])
    );
  end

  // register state
  logic [3:0]       ctrl_r, ctrl_nxt;
  logic [DATA_W-1:0] lim_low_r, lim_low_nxt;
  logic [DATA_W-1:0] lim_high_r, lim_high_nxt;
  logic [INC_W-1:0] inc_r [NUM_SEG];
  logic [INC_W-1:0] inc_nxt [NUM_SEG];
  logic [CFG_W-1:0] cfg_r [NUM_SEG];
  logic [CFG_W-1:0] cfg_nxt [NUM_SEG];
  logic [DATA_W-1:0] prdata_r, prdata_nxt;
  logic             pready_r, pready_nxt;
  logic             pslverr_r, pslverr_nxt;

  // sequencer state
  seq_state_e       state_r, state_nxt;
  logic [SEG_W-1:0] seg_r, seg_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic             phase_r, phase_nxt;
  logic [ACC_W-1:0] acc_r, acc_nxt;
  logic             en_d_r, en_d_nxt;
  logic [1:0]       flag_r, flag_nxt;
  logic             fl_r, fl_nxt;
  logic             run_r, run_nxt;

  logic             in_seg_area;
  logic [SEG_W-1:0] addr_seg;
  logic             wr_en;
  logic [ACC_W-1:0] lim_low, lim_high;

  // a write lands on the edge that completes the access phase, never on error
  assign in_seg_area = (paddr[7:6] == SEG_AREA);
  assign addr_seg    = paddr[5:3];
  assign wr_en       = psel & penable & pready_r & pwrite & ~pslverr_r;
  assign lim_low     = {ctrl_r[CTRL_LOW_MSB_BIT], lim_low_r};
  assign lim_high    = {ctrl_r[CTRL_HIGH_MSB_BIT], lim_high_r};

  // load value of a segment's length counter; zero stands for the full range
  function automatic logic [CNT_W-1:0] len_load(input logic [CFG_W-1:0] cfg);
    logic [LEN_W-1:0] len;
    len = cfg[CFG_LEN_LSB +: LEN_W];
    len_load = (len == '0) ? LEN_FULL : {1'b0, len}; // [R03]
  endfunction

  // apb: one wait state, answer registered on the first access cycle
  // unmapped words answer with pslverr and read as zero
  always_comb begin
    ctrl_nxt     = ctrl_r;
    lim_low_nxt  = lim_low_r;
    lim_high_nxt = lim_high_r;
    inc_nxt      = inc_r;
    cfg_nxt      = cfg_r;
    pready_nxt   = psel & penable & ~pready_r;
    prdata_nxt   = '0;
    pslverr_nxt  = 1'b0;
    if (psel & penable & ~pready_r) begin
      if (paddr == CTRL_OFS) begin
        prdata_nxt = {28'h000_0000, ctrl_r};
      end else if (paddr == LIMIT_LOW_OFS) begin
        prdata_nxt = lim_low_r;
      end else if (paddr == LIMIT_HIGH_OFS) begin
        prdata_nxt = lim_high_r;
      end else if (paddr == STATUS_OFS) begin
        // snapshot of the sequencer taken while the access phase is open
        prdata_nxt = '0;
        prdata_nxt[STAT_SEG_LSB +: SEG_W] = seg_r;
        prdata_nxt[STAT_RUN_BIT]          = (state_r == SEQ_RUN);
        prdata_nxt[STAT_MSB_BIT]          = acc_r[ACC_W-1];
        prdata_nxt[STAT_FL_BIT]           = fl_r;
        prdata_nxt[STAT_FLAG_LSB +: 2]    = flag_r;
      end else if (paddr == ACC_OFS) begin
        prdata_nxt = acc_r[DATA_W-1:0];
      end else if (in_seg_area && paddr[1:0] == 2'h0) begin
        if (paddr[2]) begin
          prdata_nxt = {7'h00, cfg_r[addr_seg]};
        end else begin
          prdata_nxt = {2'h0, inc_r[addr_seg]};
        end
      end else begin
        pslverr_nxt = 1'b1;
      end
    end
    // an error answer lasts only as long as pready
    if (pready_r) begin
      pslverr_nxt = 1'b0;
    end
    if (wr_en) begin
      if (paddr == CTRL_OFS) begin
        ctrl_nxt = pwdata[3:0];
      end else if (paddr == LIMIT_LOW_OFS) begin
        lim_low_nxt = pwdata;
      end else if (paddr == LIMIT_HIGH_OFS) begin
        lim_high_nxt = pwdata;
      end else if (paddr == STATUS_OFS || paddr == ACC_OFS) begin
        // read-only words: the write completes without error and is dropped
      end else if (in_seg_area) begin
        if (paddr[2]) begin
          cfg_nxt[addr_seg] = pwdata[CFG_W-1:0]; // [R09]
        end else begin
          inc_nxt[addr_seg] = pwdata[INC_W-1:0]; // [R09]
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r     <= CTRL_RST;
      lim_low_r  <= LIMIT_LOW_RST[DATA_W-1:0];
      lim_high_r <= LIMIT_HIGH_RST[DATA_W-1:0];
      for (int i = 0; i < NUM_SEG; i++) begin
        inc_r[i] <= INC_RST; // [R11]
        cfg_r[i] <= CFG_RST; // [R11]
      end
      prdata_r  <= '0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      ctrl_r     <= ctrl_nxt;
      lim_low_r  <= lim_low_nxt;
      lim_high_r <= lim_high_nxt;
      inc_r      <= inc_nxt;
      cfg_r      <= cfg_nxt;
      prdata_r   <= prdata_nxt;
      pready_r   <= pready_nxt;
      pslverr_r  <= pslverr_nxt;
    end
  end

  // sequencer
  logic [CFG_W-1:0]   cur_cfg;
  logic               half_rate;
  logic               tick;
  logic               advance;
  logic [1:0]         adv_sel;
  logic signed [ACC_W:0] sum;

  always_comb begin
    cur_cfg   = cfg_r[seg_r];
    half_rate = cur_cfg[CFG_HALF_BIT];
    adv_sel   = cur_cfg[CFG_ADV_LSB +: 2];
    state_nxt = state_r;
    seg_nxt   = seg_r;
    cnt_nxt   = cnt_r;
    phase_nxt = 1'b0;
    acc_nxt   = acc_r;
    en_d_nxt  = ctrl_r[CTRL_EN_BIT];
    tick      = 1'b0;
    advance   = 1'b0;
    // sum is one bit wider than the accumulator, so a step never wraps
    sum       = $signed({acc_r[ACC_W-1], acc_r})
              + $signed({{(ACC_W+1-INC_W){inc_r[seg_r][INC_W-1]}}, inc_r[seg_r]});
    case (state_r)
      SEQ_IDLE: begin
        // only a fresh 0 to 1 step of enable starts a pattern
        if (ctrl_r[CTRL_EN_BIT] & ~en_d_r) begin
          state_nxt = SEQ_RUN;
          seg_nxt   = '0; // [R11]
          cnt_nxt   = len_load(cfg_r[0]);
        end
      end
      SEQ_RUN: begin
        // a half-rate tick completes on the second cycle
        tick      = ~half_rate | (phase_r == 1'(HALF_RATE_CYCLES - 1)); // [R02]
        phase_nxt = half_rate & ~phase_r; // [R02]
        if (tick && cnt_r != '0) begin
          cnt_nxt = cnt_r - 17'h0_0001; // [R03]
          // a step that would cross a limit saturates at that limit
          if (sum > $signed({lim_high[ACC_W-1], lim_high})) begin
            acc_nxt = lim_high; // [R10]
          end else if (sum < $signed({lim_low[ACC_W-1], lim_low})) begin
            acc_nxt = lim_low; // [R10]
          end else begin
            acc_nxt = sum[ACC_W-1:0]; // [R03]
          end
        end
        // expiry advances on the last tick, whose increment still applies
        if (adv_sel == ADV_LENGTH) begin
          advance = tick & (cnt_r == 17'h0_0001); // [R07]
        end else begin
          // select codes 1 to 3 pick the pulses of triggers a to c
          advance = trig_pulse[adv_sel - 2'h1]; // [R07]
        end
        if (advance) begin
          seg_nxt   = cur_cfg[CFG_NEXT_LSB +: SEG_W]; // [R08]
          cnt_nxt   = len_load(cfg_r[seg_nxt]);
          phase_nxt = 1'b0;
        end
        // dropping enable stops the ramp; the accumulator keeps its value
        if (!ctrl_r[CTRL_EN_BIT]) begin
          state_nxt = SEQ_IDLE;
          phase_nxt = 1'b0;
        end
      end
      default: begin
        state_nxt = SEQ_IDLE;
      end
    endcase
    // clear is a level: the accumulator stays zero while it is set
    if (ctrl_r[CTRL_CLR_BIT]) begin
      acc_nxt = '0; // [R05]
    end
    // outputs follow the next state so they change together with the segment
    if (state_nxt == SEQ_RUN) begin
      flag_nxt = cfg_r[seg_nxt][CFG_FLAG_LSB +: 2]; // [R04]
      fl_nxt   = cfg_r[seg_nxt][CFG_FL_BIT]; // [R01]
      run_nxt  = 1'b1;
    end else begin
      flag_nxt = 2'h0;
      fl_nxt   = 1'b0;
      run_nxt  = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= SEQ_IDLE;
      seg_r   <= '0;
      cnt_r   <= '0;
      phase_r <= 1'b0;
      acc_r   <= '0;
      en_d_r  <= 1'b0;
      flag_r  <= 2'h0;
      fl_r    <= 1'b0;
      run_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      seg_r   <= seg_nxt;
      cnt_r   <= cnt_nxt;
      phase_r <= phase_nxt;
      acc_r   <= acc_nxt;
      en_d_r  <= en_d_nxt;
      flag_r  <= flag_nxt;
      fl_r    <= fl_nxt;
      run_r   <= run_nxt;
    end
  end

  assign prdata           = prdata_r;
  assign pready           = pready_r;
  assign pslverr          = pslverr_r;
  assign ramp_accumulator = acc_r;
  assign flag_out_zero    = flag_r[0]; // [R04]
  assign flag_out_one     = flag_r[1]; // [R04]
  assign fastlock_active  = fl_r; // [R01]
  assign active_segment   = seg_r;
  assign ramp_running     = run_r;

endmodule
`default_nettype wire

// ==== ramp_seq_asserts.sv ====
`default_nettype none
module ramp_seq_chk
  import ramp_seq_pkg::*;
(
  // clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // apb
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // ramp outputs
  input wire logic              flag_out_zero,
  input wire logic              flag_out_one,
  input wire logic              fastlock_active,
  input wire logic [SEG_W-1:0]  active_segment,
  input wire logic              ramp_running
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc_ph = psel && penable && !pready;
  AST_ONE_WAIT: assert property ($rose(penable) && psel |=> pready)
    else $error("pready not one cycle after access");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == '0)
    else $error("prdata not zero outside answer");
  AST_UNMAPPED: assert property (acc_ph && paddr inside {[8'h14:8'h3f]} |=> pslverr)
    else $error("unmapped access without error");
  AST_OUT_IDLE: assert property (!ramp_running |-> !(flag_out_zero || flag_out_one))
    else $error("flags high while idle");
  AST_FL_IDLE: assert property (!ramp_running |-> !fastlock_active)
    else $error("fastlock high while idle");
  AST_START_SEG0: assert property ($rose(ramp_running) |-> active_segment == '0)
    else $error("run did not start at segment zero");
  AST_SEG_FROZEN: assert property (!ramp_running ##1 !ramp_running |-> $stable(active_segment))
    else $error("segment moved while idle");
endmodule
bind ramp_segment_sequencer ramp_seq_chk i_chk (.pclk, .presetn, .psel, .penable, .paddr,
  .prdata, .pready, .pslverr, .flag_out_zero, .flag_out_one, .fastlock_active,
  .active_segment, .ramp_running);
`default_nettype wire

// ==== trig_src.sv ====
`default_nettype none
module trig_src (
  // clock
  input  wire logic       pclk,
  // fire request, one bit per source
  input  wire logic [2:0] fire,
  // trigger levels
  output logic      [2:0] trig
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] trig_r = 3'h0;
  logic [2:0] trig_nxt;
  logic [2:0] cnt_r = 3'h0;
  logic [2:0] cnt_nxt;
  // hold a fired level long enough for the synchroniser to see one edge
  always_comb begin
    trig_nxt = trig_r;
    cnt_nxt  = cnt_r;
    if (fire != 3'h0) begin
      trig_nxt = fire;
      cnt_nxt  = 3'h6;
    end else if (cnt_r != 3'h0) begin
      cnt_nxt = cnt_r - 3'h1;
    end else begin
      trig_nxt = 3'h0;
    end
  end
  always_ff @(posedge pclk) begin
    trig_r <= trig_nxt;
    cnt_r  <= cnt_nxt;
  end
  assign trig = trig_r;
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`default_nettype none
module tb_top
  import ramp_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [2:0]  fire    = 3'h0;
  logic [31:0] prdata, rdat;
  logic        pready, pslverr, rerr, fz, fo, fl, run;
  logic [2:0]  trg, seg;
  logic [32:0] acc;
  int          error_cnt = 0;
  int          n_checks  = 0;
  ramp_segment_sequencer i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .trigger_event_a(trg[0]), .trigger_event_b(trg[1]),
    .trigger_event_c(trg[2]), .ramp_accumulator(acc), .flag_out_zero(fz),
    .flag_out_one(fo), .fastlock_active(fl), .active_segment(seg), .ramp_running(run));
  trig_src i_trig (.pclk, .fire, .trig(trg));
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      error_cnt++;
      end_of_test();
    end
    @(posedge pclk);
  endtask
  task automatic pulse(input logic [2:0] f);
    fire <= f;
    @(posedge pclk);
    fire <= 3'h0;
    @(posedge pclk);
  endtask
  task automatic wseg(input logic [2:0] s);
    int n;
    n = 0;
    while (seg !== s && n < 60) begin
      @(posedge pclk);
      n++;
    end
    chk("segment", {30'h0, s}, {30'h0, seg});
    if (n >= 60) begin
      end_of_test();
    end
  endtask
  task automatic t_reset();
    chk("acc reset", 33'h0, acc);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl reset", 33'h8, {1'b0, rdat});
    apb(1'b0, LIMIT_HIGH_OFS, 32'h0);
    chk("limit high reset", {1'b0, LIMIT_HIGH_RST[31:0]}, {1'b0, rdat});
    apb(1'b1, 8'h7c, 32'h00c0_0001);
    apb(1'b0, 8'h74, 32'h0);
    chk("seg6 cfg", 33'h0, {1'b0, rdat});
    apb(1'b0, 8'h7c, 32'h0);
    chk("seg7 cfg", 33'h00c0_0001, {1'b0, rdat});
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", 33'h1, {32'h0, rerr});
    $display("t_reset done");
  endtask
  task automatic t_run();
    int n;
    apb(1'b1, LIMIT_LOW_OFS, 32'hffff_fff0);
    apb(1'b1, LIMIT_HIGH_OFS, 32'h0000_ffff);
    apb(1'b1, 8'h40, 32'h5);
    apb(1'b1, 8'h44, 32'h0056_0003);
    apb(1'b1, 8'h48, 32'h2);
    apb(1'b1, 8'h4c, 32'h00f9_0004);
    apb(1'b1, 8'h58, 32'h3fff_fffe);
    apb(1'b1, 8'h5c, 32'h00cc_0002);
    apb(1'b1, CTRL_OFS, 32'h6);
    apb(1'b1, CTRL_OFS, 32'h5);
    repeat (20) @(posedge pclk);
    chk("acc seg0", 33'hf, acc);
    chk("flags seg0", 33'h1, {31'h0, fo, fz});
    chk("fastlock seg0", 33'h1, {32'h0, fl});
    pulse(3'h2);
    repeat (10) @(posedge pclk);
    chk("other trigger", 33'h0, {30'h0, seg});
    pulse(3'h1);
    wseg(3'h1);
    n = 0;
    while (acc !== 33'h17 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk("half rate", 33'(4 * HALF_RATE_CYCLES), 33'(n));
    repeat (6) @(posedge pclk);
    chk("acc seg1", 33'h17, acc);
    chk("flags seg1", 33'h2, {31'h0, fo, fz});
    chk("fastlock seg1", 33'h0, {32'h0, fl});
    pulse(3'h4);
    wseg(3'h3);
    repeat (40) @(posedge pclk);
    chk("acc clamp", 33'h1_ffff_fff0, acc);
    chk("seg3 loop", 33'h3, {30'h0, seg});
    chk("flags seg3", 33'h3, {31'h0, fo, fz});
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("status seg3", 33'hdb, {1'b0, rdat});
    $display("t_run done");
  endtask
  task automatic t_stop();
    apb(1'b1, CTRL_OFS, 32'h4);
    repeat (3) @(posedge pclk);
    chk("stopped", 33'h0, {32'h0, run});
    chk("acc held", 33'h1_ffff_fff0, acc);
    apb(1'b1, CTRL_OFS, 32'h6);
    apb(1'b0, ACC_OFS, 32'h0);
    chk("acc reg", 33'h0, {1'b0, rdat});
    chk("acc out", 33'h0, acc);
    apb(1'b1, CTRL_OFS, 32'h4);
    $display("t_stop done");
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_run();
    t_stop();
    end_of_test();
  end
endmodule
`default_nettype wire
